// file: core/bmm_pkg.sv
// Purpose: shared constants for the boot memory map controller
// Assumes: 16-bit code and data address spaces of the core
// Notes: register offsets are byte addresses on the ahb-lite slave
package bmm_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] CFG_OFFSET = 8'h00;
  localparam logic [7:0] USB_CONTROL_REG_OFFSET = 8'h04;

  // ==========================================================
  // configuration register fields and reset values
  localparam int MAP_SWITCH_BIT = 0;
  localparam int REV_LSB = 1;
  localparam int REV_MSB = 4;
  localparam int OVC_EN_BIT = 5;
  localparam int IRQ_SEL_BIT = 6;
  localparam int RSV_BIT = 7;
  localparam int USB_CONNECT_BIT = 7;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [3:0] REVISION_DEFAULT = 4'h1; // arbitrary value

  // ==========================================================
  // memory windows
  localparam logic [15:0] ROM_LO_BASE = 16'h0000;
  localparam logic [15:0] ROM_LO_LAST = 16'h17FF;
  localparam logic [15:0] ROM_HI_BASE = 16'h8000;
  localparam logic [15:0] ROM_HI_LAST = 16'h97FF;
  localparam logic [15:0] RAM_BASE = 16'h0000;
  localparam logic [15:0] RAM_LAST = 16'h1FFF;
  localparam logic [15:0] IO_BASE = 16'hFD80;
  localparam logic [15:0] IO_LAST = 16'hFFFF;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // ==========================================================
  // bus constants
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

endpackage

// file: core/bmm_window.sv
// Purpose: decode one address window, inclusive bounds
// Assumes: combinational, same clock as the caller
// Notes: instantiated once per window and port; the ram window twice
`timescale 1ns/1ps
`default_nettype none
module bmm_window #(
  parameter logic [15:0] BASE = 16'h0000,
  parameter logic [15:0] LAST = 16'hFFFF
) (
  // address in
  input wire logic [15:0] addr,
  // window hit
  output logic hit
);
  assign hit = (addr >= BASE) && (addr <= LAST);
endmodule
`default_nettype wire

// file: core/bmm_ctrl.sv
// Purpose: boot memory map control and configuration register
// Assumes: core issues code and data accesses on its own ports
// Notes: registers reached over ahb-lite, zero wait states
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - map bit clear: boot rom at code 0000-17FF and mirror 8000-97FF.
// - map bit clear: 8K ram in data space at 0000-1FFF.
// - both modes: buffers, registers, i/o in data space FD80-FFFF.
// - map bit set: boot rom only at code 8000-97FF.
// - map bit set: 8K ram in code space at 0000-1FFF.
// - reset clears map bit and usb connect bit.
// - after reset the first fetch is from 0000, in boot rom.
// - boot code loads ram from eeprom if signed, else over usb.
// - boot code sets map bit first, then usb connect bit.
// - software can set map bit but never clear it; reset only.
// - boot mode allows ram reads and writes via data space.
// - normal mode blocks every ram write.
// - revision read-only in bits 4-1; writes ignored.
// - bit 5, reset 0, enables hub overcurrent detection.
// - bit 6, reset 0, picks irq one source: pin or port2 or.
module bmm_ctrl #(
  parameter logic [3:0] REVISION = bmm_pkg::REVISION_DEFAULT
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // core code port
  input wire logic [15:0] code_addr,
  output logic code_rom_sel,
  output logic code_ram_sel,
  // core data port
  input wire logic [15:0] data_addr,
  input wire logic data_wr,
  output logic data_ram_sel,
  output logic data_ram_wr_en,
  output logic data_io_sel,
  // first fetch address after reset
  output logic [15:0] reset_vector,
  // mode and usb state
  output logic map_switch_bit,
  output logic usb_connect_bit,
  output logic overcurrent_detect_enable,
  // external interrupt one
  input wire logic port3_pin3,
  input wire logic [7:0] port2_in,
  output logic external_irq_one
);

  // ==========================================================
  // bus address phase capture
  logic wr_pend_q, wr_pend_d;
  logic [7:0] wr_addr_q, wr_addr_d;
  logic rd_pend_q, rd_pend_d;
  logic take;

  assign take = hsel && hready &&
    (htrans == bmm_pkg::HTRANS_NONSEQ || htrans == bmm_pkg::HTRANS_SEQ);

  always_comb begin
    wr_pend_d = take && hwrite;
    rd_pend_d = take && !hwrite;
    wr_addr_d = take ? haddr : wr_addr_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= wr_pend_d;
      rd_pend_q <= rd_pend_d;
      wr_addr_q <= wr_addr_d;
    end
  end

  // zero wait states; every access answers okay, unmapped reads zero
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ==========================================================
  // configuration and usb control state
  logic map_q, map_d;
  logic ovc_q, ovc_d;
  logic irq_sel_q, irq_sel_d;
  logic rsv_q, rsv_d;
  logic conn_q, conn_d;
  logic cfg_wr, usb_wr;

  assign cfg_wr = wr_pend_q && (wr_addr_q == bmm_pkg::CFG_OFFSET);
  assign usb_wr = wr_pend_q && (wr_addr_q == bmm_pkg::USB_CONTROL_REG_OFFSET);

  always_comb begin
    map_d = map_q;
    ovc_d = ovc_q;
    irq_sel_d = irq_sel_q;
    rsv_d = rsv_q;
    conn_d = conn_q;
    if (cfg_wr) begin
      // a written zero leaves the map bit set: only reset clears it
      map_d = map_q | hwdata[bmm_pkg::MAP_SWITCH_BIT];
      ovc_d = hwdata[bmm_pkg::OVC_EN_BIT];
      irq_sel_d = hwdata[bmm_pkg::IRQ_SEL_BIT];
      rsv_d = hwdata[bmm_pkg::RSV_BIT];
      // revision bits are not stored, so writes cannot change them
    end
    if (usb_wr) begin
      conn_d = hwdata[bmm_pkg::USB_CONNECT_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      map_q <= bmm_pkg::CFG_RESET[bmm_pkg::MAP_SWITCH_BIT];
      ovc_q <= bmm_pkg::CFG_RESET[bmm_pkg::OVC_EN_BIT];
      irq_sel_q <= bmm_pkg::CFG_RESET[bmm_pkg::IRQ_SEL_BIT];
      rsv_q <= bmm_pkg::CFG_RESET[bmm_pkg::RSV_BIT];
      conn_q <= 1'b0;
    end else begin
      map_q <= map_d;
      ovc_q <= ovc_d;
      irq_sel_q <= irq_sel_d;
      rsv_q <= rsv_d;
      conn_q <= conn_d;
    end
  end

  // ==========================================================
  // read data, registered so the bus sees clean flop outputs;
  // built from the next-state view, so a read whose address phase
  // overlaps a write's data phase already returns the new value
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] cfg_view;
  logic [7:0] usb_view;

  always_comb begin
    cfg_view = 8'h00;
    cfg_view[bmm_pkg::MAP_SWITCH_BIT] = map_d;
    cfg_view[bmm_pkg::REV_MSB:bmm_pkg::REV_LSB] = REVISION;
    cfg_view[bmm_pkg::OVC_EN_BIT] = ovc_d;
    cfg_view[bmm_pkg::IRQ_SEL_BIT] = irq_sel_d;
    cfg_view[bmm_pkg::RSV_BIT] = rsv_d;
    usb_view = 8'h00;
    usb_view[bmm_pkg::USB_CONNECT_BIT] = conn_d;
    rdata_d = 32'h0000_0000;
    if (take && !hwrite) begin
      case (haddr)
        bmm_pkg::CFG_OFFSET: begin
          rdata_d = {24'h00_0000, cfg_view};
        end
        bmm_pkg::USB_CONTROL_REG_OFFSET: begin
          rdata_d = {24'h00_0000, usb_view};
        end
        default: begin
          // unmapped offsets read as zero
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign hrdata = rd_pend_q ? rdata_q : 32'h0000_0000;

  // ==========================================================
  // address decode; map_q is a single flop so the decode switches
  // in one clean step right after the write's data phase
  logic c_rom_lo, c_rom_hi, c_ram, d_ram, d_io;

  bmm_window #(
    .BASE(bmm_pkg::ROM_LO_BASE),
    .LAST(bmm_pkg::ROM_LO_LAST)
  ) u_code_rom_lo (
    .addr(code_addr),
    .hit(c_rom_lo)
  );

  bmm_window #(
    .BASE(bmm_pkg::ROM_HI_BASE),
    .LAST(bmm_pkg::ROM_HI_LAST)
  ) u_code_rom_hi (
    .addr(code_addr),
    .hit(c_rom_hi)
  );

  bmm_window #(
    .BASE(bmm_pkg::RAM_BASE),
    .LAST(bmm_pkg::RAM_LAST)
  ) u_code_ram (
    .addr(code_addr),
    .hit(c_ram)
  );

  bmm_window #(
    .BASE(bmm_pkg::RAM_BASE),
    .LAST(bmm_pkg::RAM_LAST)
  ) u_data_ram (
    .addr(data_addr),
    .hit(d_ram)
  );

  bmm_window #(
    .BASE(bmm_pkg::IO_BASE),
    .LAST(bmm_pkg::IO_LAST)
  ) u_data_io (
    .addr(data_addr),
    .hit(d_io)
  );

  always_comb begin
    if (!map_q) begin
      code_rom_sel = c_rom_lo || c_rom_hi;
      code_ram_sel = 1'b0;
      data_ram_sel = d_ram;
      // boot code copies its image into ram through this path
      data_ram_wr_en = d_ram && data_wr;
    end else begin
      code_rom_sel = c_rom_hi;
      code_ram_sel = c_ram;
      // ram now holds code, so the data port may not touch it
      data_ram_sel = 1'b0;
      data_ram_wr_en = 1'b0;
    end
  end

  assign data_io_sel = d_io;

  // boot rom sits at the vector while the map bit is clear
  assign reset_vector = bmm_pkg::RESET_VECTOR;

  // ==========================================================
  // mode outputs; sequencing of load, switch, connect is firmware's
  // job, the hardware only keeps both bits clear from reset
  assign map_switch_bit = map_q;
  assign usb_connect_bit = conn_q;
  assign overcurrent_detect_enable = ovc_q;

  // ==========================================================
  // external irq one source, pins synchronised first
  logic p33_s1_q, p33_s2_q;
  logic [7:0] p2_s1_q, p2_s2_q;
  logic irq_q, irq_d;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p33_s1_q <= 1'b0;
      p33_s2_q <= 1'b0;
      p2_s1_q <= 8'h00;
      p2_s2_q <= 8'h00;
    end else begin
      p33_s1_q <= port3_pin3;
      p33_s2_q <= p33_s1_q;
      p2_s1_q <= port2_in;
      p2_s2_q <= p2_s1_q;
    end
  end

  always_comb begin
    irq_d = irq_sel_q ? (|p2_s2_q) : p33_s2_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign external_irq_one = irq_q;

endmodule
`default_nettype wire

// file: testbench/bmm_ctrl_monitor.sv
// Purpose: port checker for bmm_ctrl
// Assumes: one clock, async active-low reset
// Notes: bound to every bmm_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module bmm_ctrl_monitor (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // core ports
  input wire logic [15:0] code_addr,
  input wire logic code_rom_sel,
  input wire logic code_ram_sel,
  input wire logic [15:0] data_addr,
  input wire logic data_wr,
  input wire logic data_ram_sel,
  input wire logic data_ram_wr_en,
  input wire logic data_io_sel,
  input wire logic [15:0] reset_vector,
  // mode
  input wire logic map_switch_bit,
  input wire logic usb_connect_bit
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic m;
  logic lo;
  logic hi;
  assign m = map_switch_bit;
  assign lo = code_addr <= 16'h17FF;
  assign hi = code_addr >= 16'h8000 && code_addr <= 16'h97FF;
  // ====================
  // decode
  property p_rom_boot; !m |-> code_rom_sel == (lo || hi); endproperty
  a_rom_boot: assert property (p_rom_boot)
    else $error("boot rom decode wrong");
  property p_dram; !m |-> data_ram_sel == (data_addr <= 16'h1FFF);
  endproperty
  a_dram: assert property (p_dram)
    else $error("data ram decode wrong");
  property p_io; data_io_sel == (data_addr >= 16'hFD80); endproperty
  a_io: assert property (p_io)
    else $error("io decode wrong");
  property p_rom_norm; m |-> code_rom_sel == hi; endproperty
  a_rom_norm: assert property (p_rom_norm)
    else $error("normal rom decode wrong");
  property p_cram; m |-> code_ram_sel == (code_addr <= 16'h1FFF);
  endproperty
  a_cram: assert property (p_cram)
    else $error("code ram decode wrong");
  // ====================
  // mode bits
  property p_rst; $rose(hresetn) |-> !m && !usb_connect_bit; endproperty
  a_rst: assert property (p_rst)
    else $error("mode bits not clear after reset");
  property p_vec; reset_vector == 16'h0000; endproperty
  a_vec: assert property (p_vec)
    else $error("first fetch address wrong");
  property p_sticky; m |=> m; endproperty
  a_sticky: assert property (p_sticky)
    else $error("map bit cleared without reset");
  property p_boot_wr;
    !m |-> data_ram_wr_en == (data_wr && data_addr <= 16'h1FFF);
  endproperty
  a_boot_wr: assert property (p_boot_wr)
    else $error("boot ram write enable wrong");
  property p_no_wr; m |-> !data_ram_wr_en && !data_ram_sel; endproperty
  a_no_wr: assert property (p_no_wr)
    else $error("ram writable in normal mode");
endmodule
bind bmm_ctrl bmm_ctrl_monitor u_bmm_ctrl_monitor (.*);
`default_nettype wire

// file: testbench/bmm_core_model.sv
// Purpose: core model issuing code and data accesses
// Assumes: changes only after rising edges
// Notes: window edges are picked half the time
`timescale 1ns/1ps
`default_nettype none
module bmm_core_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // start address
  input wire logic [15:0] reset_vector,
  // accesses
  output logic [15:0] code_addr,
  output logic [15:0] data_addr,
  output logic data_wr
);
  localparam logic [15:0] EDGE_A [8] = '{16'h17FF, 16'h1800, 16'h8000,
    16'h97FF, 16'h9800, 16'h1FFF, 16'h2000, 16'hFD80};
  function automatic logic [15:0] pick(input logic [31:0] r);
    return r[0] ? EDGE_A[r[3:1]] : r[31:16];
  endfunction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code_addr <= reset_vector;
      data_addr <= 16'h0000;
      data_wr <= 1'h0;
    end else begin
      code_addr <= pick($urandom);
      data_addr <= pick($urandom);
      data_wr <= 1'($urandom);
    end
  end
endmodule
`default_nettype wire

// file: testbench/bmm_ctrl_bench.sv
// Purpose: self-checking bench for bmm_ctrl
// Assumes: zero-wait slave, waits still bounded
// Notes: decode checked at falling edges
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
  n_fail++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module bmm_ctrl_bench;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, data_wr;
  logic [7:0] haddr, port2_in;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [15:0] code_addr, data_addr, reset_vector;
  logic code_rom_sel, code_ram_sel, data_ram_sel, data_ram_wr_en;
  logic data_io_sel, map_switch_bit, usb_connect_bit, port3_pin3;
  logic overcurrent_detect_enable, external_irq_one, exp_map;
  int n_fail, n_compared;
  bmm_ctrl u_bmm_ctrl (.hready(hreadyout), .*);
  bmm_core_model u_bmm_core_model (.*);
  initial begin
    hclk = 1'h0;
    forever #2.5 hclk = ~hclk;
  end
  // ====================
  // helpers
  task automatic wrap_up;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 100);
    if (hreadyout !== 1'h1) begin
      n_fail++;
      wrap_up();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= bmm_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
    `CHK("resp", 1'h0, hresp)
  endtask
  // b holds bits 7, 6, 5 and 0 of the expected configuration value
  function automatic logic [31:0] cfg(input logic [3:0] b);
    return {24'h00_0000, b[3:1], bmm_pkg::REVISION_DEFAULT, b[0]};
  endfunction
  function automatic logic rom(input logic [15:0] a);
    return (!exp_map && a <= 16'h17FF) || (a >= 16'h8000 && a <= 16'h97FF);
  endfunction
  task automatic decode(input int cyc);
    repeat (cyc) begin
      @(negedge hclk);
      `CHK("rom", rom(code_addr), code_rom_sel)
      `CHK("cram", exp_map && code_addr <= 16'h1FFF, code_ram_sel)
      `CHK("dram", !exp_map && data_addr <= 16'h1FFF, data_ram_sel)
      `CHK("wr", !exp_map && data_wr && data_addr <= 16'h1FFF,
           data_ram_wr_en)
      `CHK("io", data_addr >= 16'hFD80, data_io_sel)
    end
    @(posedge hclk);
  endtask
  // irq output lags the raw pins by three edges; four are allowed
  task automatic irq(input logic sel);
    repeat (6) begin
      port2_in <= 8'($urandom);
      port3_pin3 <= 1'($urandom);
      repeat (4) @(posedge hclk);
      `CHK("irq", sel ? |port2_in : port3_pin3, external_irq_one)
    end
  endtask
  // ====================
  // sequence
  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    port3_pin3 = 1'h0;
    port2_in = 8'h00;
    n_fail = 0;
    n_compared = 0;
    exp_map = 1'h0;
    void'($urandom(32'hFE9C));
    repeat (12) @(posedge hclk);
    `CHK("vec", 16'h0000, reset_vector)
    `CHK("vec_rom", 1'h1, code_rom_sel)
    hresetn <= 1'h1;
    @(posedge hclk);
    xfer(1'h0, bmm_pkg::CFG_OFFSET, 32'h0);
    `CHK("cfg", cfg(4'h0), rd)
    xfer(1'h0, bmm_pkg::USB_CONTROL_REG_OFFSET, 32'h0);
    `CHK("usb", 32'h0, rd)
    decode(200);
    xfer(1'h1, bmm_pkg::CFG_OFFSET, 32'hFE);
    xfer(1'h0, bmm_pkg::CFG_OFFSET, 32'h0);
    `CHK("cfg", cfg(4'hE), rd)
    `CHK("ovc", 1'h1, overcurrent_detect_enable)
    irq(1'h1);
    xfer(1'h1, bmm_pkg::CFG_OFFSET, 32'h20);
    irq(1'h0);
    xfer(1'h1, 8'h10, 32'hFF);
    xfer(1'h0, 8'h10, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    xfer(1'h1, bmm_pkg::CFG_OFFSET, 32'h21);
    exp_map = 1'h1;
    // the new map must hold from the very next cycle on
    decode(4);
    xfer(1'h1, bmm_pkg::USB_CONTROL_REG_OFFSET, 32'h80);
    // the connect flop loads at the edge that ends the data phase
    @(posedge hclk);
    `CHK("conn", 1'h1, usb_connect_bit)
    xfer(1'h1, bmm_pkg::CFG_OFFSET, 32'h0);
    xfer(1'h0, bmm_pkg::CFG_OFFSET, 32'h0);
    `CHK("cfg", cfg(4'h1), rd)
    decode(200);
    hresetn <= 1'h0;
    repeat (3) @(posedge hclk);
    `CHK("map", 1'h0, map_switch_bit)
    `CHK("conn", 1'h0, usb_connect_bit)
    exp_map = 1'h0;
    hresetn <= 1'h1;
    @(posedge hclk);
    decode(50);
    wrap_up();
  end
endmodule
`default_nettype wire
